// ==== rtl/nec_defs.svh ====
`ifndef NEC_DEFS_SVH
`define NEC_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define NEC_OFS_DATA_WIN    12'h000
`define NEC_OFS_FIX_WIN     12'h004
`define NEC_OFS_BUSY        12'h008
`define NEC_OFS_SUMMARY     12'h00C
`define NEC_OFS_MODE        12'h010
`define NEC_OFS_UNLOCK      12'h014
`define NEC_OFS_SWRST       12'h018
`define NEC_OFS_OUTCOME     12'h040
`define NEC_OFS_POS         12'h080

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define NEC_UNLOCK_KEY      8'h6B
`define NEC_KEY_RESET       8'h00
`define NEC_MODE_STRENGTH   0
`define NEC_MODE_AUTOFIX    1
`define NEC_MODE_DIRECTION  2
`define NEC_CNT_UNCORR      4'hF
`define NEC_CNT_MAX_BCH4    4'h4
`define NEC_CNT_MAX_BCH8    4'h8
`define NEC_RESP_OKAY       2'h0
`define NEC_RESP_SLVERR     2'h2

`endif

// ==== rtl/nec_pkg.sv ====
package nec_pkg;
    typedef enum logic [2:0] {
        NEC_IDLE  = 3'h1,
        NEC_WRESP = 3'h2,
        NEC_RRESP = 3'h4
    } nec_bus_e;

    typedef struct packed {
        nec_bus_e    bus;
        logic        awrdy;
        logic        wrdy;
        logic        bvld;
        logic [1:0]  bresp;
        logic        arrdy;
        logic        rvld;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] data_win;
        logic        data_stb;
        logic [31:0] fix_win;
        logic [2:0]  busy;
        logic [7:0]  summary;
        logic [2:0]  mode;
        logic [7:0]  key;
        logic [4:0]  swrst;
        logic [79:0] outcome;
        logic [831:0] pos;
    } nec_state_s;
endpackage

// ==== rtl/nec_regs.sv ====
// What this block does
// - Read-write data window passes sector words to the correction unit.
// - Read-only window shows corrected words bound for the correction RAM.
// - Busy bit 2 is high while the Chien search runs.
// - Busy bit 1 is high while the locator polynomial calculation runs.
// - Busy bit 0 is high while syndrome computation runs.
// - Summary bits 0..7 give per-sector result; 1 means no error.
// - Eight decode-state registers; clean sectors keep value under automatic correction.
// - Bits 9:8 give outcome: 00 clean, 01 correctable, 1x uncorrectable.
// - Bit 7 flags CRC error after correction, only in 4-bit automatic mode.
// - Bit 6 flags search stage found the sector uncorrectable.
// - Bit 5 flags locator stage found the sector uncorrectable.
// - Bit 4 flags CRC error despite an all-zero syndrome.
// - Bits 3:0 give error count; 1111 means uncorrectable.
// - Four position registers per sector, two 13-bit positions at 12:0, 28:16.
// - Positions are invalid when the sector outcome is uncorrectable.
// - Positions five to eight are disabled in 4-bit code mode.
// - Reset register writes take effect only while the key holds 0x6B.
// - Key resets to 0x00, leaving the reset register locked.
// - Reset bit 4 holds the flash controller in reset while set.
// - Reset bits 3..0 each hold one other unit in reset while set.
`timescale 1ns/100ps
`default_nettype none
`include "nec_defs.svh"

module nec_regs (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // AXI4-Lite write
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Engine status
    input  wire logic        CHIEN_SEARCH_BUSY,
    input  wire logic        LOCATOR_CALC_BUSY,
    input  wire logic        SYNDROME_BUSY,
    input  wire logic        FIXED_WORD_VALID,
    input  wire logic [31:0] FIXED_WORD,
    input  wire logic        SECTOR_DONE,
    input  wire logic [2:0]  SECTOR_INDEX,
    input  wire logic [1:0]  DONE_OUTCOME,
    input  wire logic [3:0]  DONE_COUNT,
    input  wire logic        DONE_POST_FIX_CRC,
    input  wire logic        DONE_SEARCH_UNCORR,
    input  wire logic        DONE_LOCATOR_UNCORR,
    input  wire logic        DONE_ZERO_SYN_CRC,
    input  wire logic [103:0] DONE_POSITIONS,
    // Engine control
    output logic [31:0]      ECC_WORD_BUFFER,
    output logic             ECC_WORD_STROBE,
    output logic             CODE_STRENGTH_SELECT,
    output logic             AUTO_FIX_SELECT,
    output logic             DIRECTION_SELECT,
    // Peripheral resets
    output logic             FLASH_CTRL_RESET,
    output logic [3:0]       UNIT_RESET
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    nec_pkg::nec_state_s st_reg;
    nec_pkg::nec_state_s st_next;

    // Pin-domain status passes two flops first
    logic [2:0] busy_meta_reg;
    logic [2:0] busy_sync_reg;

    logic [11:0] wa;
    logic [11:0] ra;
    logic [31:0] rd;
    logic        rd_hit;
    logic [2:0]  ri;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] wmask;
    logic [12:0] p_lo;
    logic [12:0] p_hi;
    logic [103:0] pos_new;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            busy_meta_reg <= 3'h0;
            busy_sync_reg <= 3'h0;
        end else begin
            busy_meta_reg <= {CHIEN_SEARCH_BUSY, LOCATOR_CALC_BUSY, SYNDROME_BUSY};
            busy_sync_reg <= busy_meta_reg;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.data_stb = 1'b0;
        wa = S_AXI_AWADDR;
        ra = S_AXI_ARADDR;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        rd = 32'h0000_0000;
        rd_hit = 1'b1;
        ri = ra[4:2];
        p_lo = 13'h0000;
        p_hi = 13'h0000;
        pos_new = DONE_POSITIONS;
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{S_AXI_WSTRB[b]}};
        end
        st_next.busy = busy_sync_reg;
        if (FIXED_WORD_VALID) begin
            st_next.fix_win = FIXED_WORD;
        end
        if (SECTOR_DONE) begin
            st_next.summary[SECTOR_INDEX] = (DONE_OUTCOME == 2'b00);
            // Clean sector under autofix keeps value
            if (!(st_reg.mode[`NEC_MODE_AUTOFIX] && DONE_OUTCOME == 2'b00)) begin
                st_next.outcome[SECTOR_INDEX*10 + 8 +: 2] = DONE_OUTCOME;
                st_next.outcome[SECTOR_INDEX*10 + 7] = DONE_POST_FIX_CRC
                    && !st_reg.mode[`NEC_MODE_STRENGTH] && st_reg.mode[`NEC_MODE_AUTOFIX];
                st_next.outcome[SECTOR_INDEX*10 + 6] = DONE_SEARCH_UNCORR;
                st_next.outcome[SECTOR_INDEX*10 + 5] = DONE_LOCATOR_UNCORR;
                st_next.outcome[SECTOR_INDEX*10 + 4] = DONE_ZERO_SYN_CRC;
                st_next.outcome[SECTOR_INDEX*10 +: 4] =
                    DONE_OUTCOME[1] ? `NEC_CNT_UNCORR : DONE_COUNT;
                // Upper positions off in 4-bit mode
                if (!st_reg.mode[`NEC_MODE_STRENGTH]) begin
                    pos_new[103:52] = 52'h0;
                end
                if (DONE_OUTCOME[1]) begin
                    pos_new = 104'h0;
                end
                st_next.pos[SECTOR_INDEX*104 +: 104] = pos_new;
            end
        end
        // Write channel: both beats taken together
        if (st_reg.bus == nec_pkg::NEC_IDLE && S_AXI_AWVALID && S_AXI_WVALID) begin
            wr_fire = 1'b1;
        end
        if (wr_fire) begin
            st_next.awrdy = 1'b1;
            st_next.wrdy = 1'b1;
            st_next.bvld = 1'b1;
            st_next.bresp = `NEC_RESP_OKAY;
            st_next.bus = nec_pkg::NEC_WRESP;
            case (wa)
                `NEC_OFS_DATA_WIN: begin
                    st_next.data_win = (st_reg.data_win & ~wmask) | (S_AXI_WDATA & wmask);
                    st_next.data_stb = 1'b1;
                end
                `NEC_OFS_MODE: begin
                    if (S_AXI_WSTRB[0]) begin
                        st_next.mode = S_AXI_WDATA[2:0];
                    end
                end
                `NEC_OFS_UNLOCK: begin
                    if (S_AXI_WSTRB[0]) begin
                        st_next.key = S_AXI_WDATA[7:0];
                    end
                end
                `NEC_OFS_SWRST: begin
                    if (S_AXI_WSTRB[0] && st_reg.key == `NEC_UNLOCK_KEY) begin
                        st_next.swrst = S_AXI_WDATA[4:0];
                    end
                end
                default: begin
                    if (wa != `NEC_OFS_FIX_WIN && wa != `NEC_OFS_BUSY
                        && wa != `NEC_OFS_SUMMARY
                        && !(wa >= `NEC_OFS_OUTCOME && wa < 12'h060)
                        && !(wa >= `NEC_OFS_POS && wa < 12'h100)) begin
                        st_next.bresp = `NEC_RESP_SLVERR;
                    end
                end
            endcase
        end else begin
            st_next.awrdy = 1'b0;
            st_next.wrdy = 1'b0;
        end
        if (st_reg.bus == nec_pkg::NEC_WRESP && st_reg.bvld && S_AXI_BREADY) begin
            st_next.bvld = 1'b0;
            st_next.bus = nec_pkg::NEC_IDLE;
        end
        // Read channel: reads lose to a same-cycle write
        if (st_reg.bus == nec_pkg::NEC_IDLE && !wr_fire && S_AXI_ARVALID) begin
            rd_fire = 1'b1;
        end
        case (ra)
            `NEC_OFS_DATA_WIN: rd = st_reg.data_win;
            `NEC_OFS_FIX_WIN:  rd = st_reg.fix_win;
            `NEC_OFS_BUSY:     rd = {29'h0, st_reg.busy};
            `NEC_OFS_SUMMARY:  rd = {24'h0, st_reg.summary};
            `NEC_OFS_MODE:     rd = {29'h0, st_reg.mode};
            `NEC_OFS_UNLOCK:   rd = {24'h0, st_reg.key};
            `NEC_OFS_SWRST:    rd = {27'h0, st_reg.swrst};
            default: begin
                if (ra >= `NEC_OFS_OUTCOME && ra < 12'h060) begin
                    rd = {22'h0, st_reg.outcome[ri*10 +: 10]};
                end else if (ra >= `NEC_OFS_POS && ra < 12'h100) begin
                    // Sector in addr 6:4, pair in 3:2
                    p_lo = st_reg.pos[ra[6:4]*104 + ra[3:2]*26 +: 13];
                    p_hi = st_reg.pos[ra[6:4]*104 + ra[3:2]*26 + 13 +: 13];
                    rd = {3'h0, p_hi, 3'h0, p_lo};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
        if (rd_fire) begin
            st_next.arrdy = 1'b1;
            st_next.rvld = 1'b1;
            st_next.rdata = rd;
            st_next.rresp = rd_hit ? `NEC_RESP_OKAY : `NEC_RESP_SLVERR;
            st_next.bus = nec_pkg::NEC_RRESP;
        end else begin
            st_next.arrdy = 1'b0;
        end
        if (st_reg.bus == nec_pkg::NEC_RRESP && st_reg.rvld && S_AXI_RREADY) begin
            st_next.rvld = 1'b0;
            st_next.bus = nec_pkg::NEC_IDLE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st_reg <= '0;
            st_reg.bus <= nec_pkg::NEC_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------
    assign S_AXI_AWREADY = st_reg.awrdy;
    assign S_AXI_WREADY = st_reg.wrdy;
    assign S_AXI_BVALID = st_reg.bvld;
    assign S_AXI_BRESP = st_reg.bresp;
    assign S_AXI_ARREADY = st_reg.arrdy;
    assign S_AXI_RVALID = st_reg.rvld;
    assign S_AXI_RDATA = st_reg.rdata;
    assign S_AXI_RRESP = st_reg.rresp;
    assign ECC_WORD_BUFFER = st_reg.data_win;
    assign ECC_WORD_STROBE = st_reg.data_stb;
    assign CODE_STRENGTH_SELECT = st_reg.mode[`NEC_MODE_STRENGTH];
    assign AUTO_FIX_SELECT = st_reg.mode[`NEC_MODE_AUTOFIX];
    assign DIRECTION_SELECT = st_reg.mode[`NEC_MODE_DIRECTION];
    assign FLASH_CTRL_RESET = st_reg.swrst[4];
    assign UNIT_RESET = st_reg.swrst[3:0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_key_locks_reset: assert property (@(posedge REF_CLK) disable iff (RESET)
        (st_reg.key != `NEC_UNLOCK_KEY) |=> $stable(st_reg.swrst))
        else $error("reset register changed while locked");
    a_key_after_reset: assert property (@(posedge REF_CLK)
        $fell(RESET) |-> st_reg.key == 8'h00)
        else $error("key not cleared by reset");
    a_busy_follows_pin: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(CHIEN_SEARCH_BUSY) ##1 CHIEN_SEARCH_BUSY[*2] |=> st_reg.busy[2])
        else $error("search busy not mirrored");
    a_search_busy_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
        $fell(CHIEN_SEARCH_BUSY) ##1 (!CHIEN_SEARCH_BUSY)[*2] |=> !st_reg.busy[2])
        else $error("search busy not cleared");
    a_locator_busy_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(LOCATOR_CALC_BUSY) ##1 LOCATOR_CALC_BUSY[*2] |=> st_reg.busy[1])
        else $error("locator busy not mirrored");
    a_syndrome_busy_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(SYNDROME_BUSY) ##1 SYNDROME_BUSY[*2] |=> st_reg.busy[0])
        else $error("syndrome busy not mirrored");
    a_uncorr_count: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME[1]
        |=> st_reg.outcome[$past(SECTOR_INDEX)*10 +: 4] == `NEC_CNT_UNCORR)
        else $error("uncorrectable count not 1111");
    a_clean_summary: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE |=> st_reg.summary[$past(SECTOR_INDEX)] == ($past(DONE_OUTCOME) == 2'b00))
        else $error("summary bit wrong");
    a_flash_reset_out: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_fire && wa == `NEC_OFS_SWRST && S_AXI_WSTRB[0] && st_reg.key == `NEC_UNLOCK_KEY
        |=> FLASH_CTRL_RESET == $past(S_AXI_WDATA[4]))
        else $error("flash reset not written");
    a_unit_reset_out: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_fire && wa == `NEC_OFS_SWRST && S_AXI_WSTRB[0] && st_reg.key == `NEC_UNLOCK_KEY
        |=> UNIT_RESET == $past(S_AXI_WDATA[3:0]))
        else $error("unit resets not written");
    a_bvalid_holds: assert property (@(posedge REF_CLK) disable iff (RESET)
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped");
    a_rvalid_holds: assert property (@(posedge REF_CLK) disable iff (RESET)
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read response dropped");
    a_fixed_capture: assert property (@(posedge REF_CLK) disable iff (RESET)
        FIXED_WORD_VALID |=> st_reg.fix_win == $past(FIXED_WORD))
        else $error("corrected word not captured");
    a_data_strobe: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_fire && wa == `NEC_OFS_DATA_WIN |=> ECC_WORD_STROBE)
        else $error("data window strobe missing");
    a_fix_win_ro: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_fire && wa == `NEC_OFS_FIX_WIN
        |=> $stable(st_reg.fix_win) || $past(FIXED_WORD_VALID))
        else $error("corrected window took a bus write");
    a_busy_read_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        rd_fire && ra == `NEC_OFS_BUSY |=> S_AXI_RDATA[31:3] == 29'h0)
        else $error("busy reserved bits not zero");
    a_outcome_field: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME != 2'b00
        |=> st_reg.outcome[$past(SECTOR_INDEX)*10 + 8 +: 2] == $past(DONE_OUTCOME))
        else $error("outcome field wrong");
    a_post_fix_masked: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME != 2'b00
        && (st_reg.mode[`NEC_MODE_STRENGTH] || !st_reg.mode[`NEC_MODE_AUTOFIX])
        |=> !st_reg.outcome[$past(SECTOR_INDEX)*10 + 7])
        else $error("post-fix CRC flag not masked");
    a_search_fault_bit: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME != 2'b00
        |=> st_reg.outcome[$past(SECTOR_INDEX)*10 + 6] == $past(DONE_SEARCH_UNCORR))
        else $error("search fault flag wrong");
    a_locator_fault_bit: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME != 2'b00
        |=> st_reg.outcome[$past(SECTOR_INDEX)*10 + 5] == $past(DONE_LOCATOR_UNCORR))
        else $error("locator fault flag wrong");
    a_zero_syn_bit: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME != 2'b00
        |=> st_reg.outcome[$past(SECTOR_INDEX)*10 + 4] == $past(DONE_ZERO_SYN_CRC))
        else $error("zero syndrome flag wrong");
    a_autofix_keeps: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME == 2'b00 && st_reg.mode[`NEC_MODE_AUTOFIX]
        |=> $stable(st_reg.outcome) && $stable(st_reg.pos))
        else $error("clean sector changed state");
    a_uncorr_pos_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME[1]
        |=> st_reg.pos[$past(SECTOR_INDEX)*104 +: 104] == 104'h0)
        else $error("positions kept on uncorrectable");
    a_upper_pos_off: assert property (@(posedge REF_CLK) disable iff (RESET)
        SECTOR_DONE && DONE_OUTCOME != 2'b00 && !st_reg.mode[`NEC_MODE_STRENGTH]
        |=> st_reg.pos[$past(SECTOR_INDEX)*104 + 52 +: 52] == 52'h0)
        else $error("upper positions live in 4-bit mode");

endmodule
`default_nettype wire

// ==== test/nec_engine_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module nec_engine_model (
    // Clock
    input  wire logic         ref_clk,
    // Data window words
    input  wire logic [31:0]  ecc_word_buffer,
    input  wire logic         ecc_word_strobe,
    // Stage activity, chien/locator/syndrome
    output logic [2:0]        stage_busy,
    // Corrected words
    output logic              fixed_word_valid,
    output logic [31:0]       fixed_word,
    // Sector results: index, outcome, count, flags
    output logic              sector_done,
    output logic [12:0]       result,
    output logic [103:0]      positions
);
    initial begin
        stage_busy = 3'h0;
        fixed_word_valid = 1'b0;
        fixed_word = 32'h0;
        sector_done = 1'b0;
        result = 13'h0;
        positions = 104'h0;
    end

    // ----------------
    // Corrected words
    // ----------------
    // One bit flipped, so a stale copy of the data window is caught
    always @(posedge ref_clk) begin
        fixed_word_valid <= ecc_word_strobe;
        fixed_word <= ecc_word_strobe ? ecc_word_buffer ^ 32'h0000_0100 : ~fixed_word;
    end

    // ----------------
    // Stage and sector reports
    // ----------------
    task automatic set_stages(input logic [2:0] b);
        @(posedge ref_clk);
        stage_busy <= b;
    endtask

    task automatic report(input logic [12:0] r, input logic [103:0] p);
        @(posedge ref_clk);
        sector_done <= 1'b1;
        result <= r;
        positions <= p;
        @(posedge ref_clk);
        sector_done <= 1'b0;
        // Result lines are stale once the pulse ends
        result <= ~r;
        positions <= ~p;
    endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "nec_defs.svh"
module tb;
    // ----------------
    // Bench signals
    // ----------------
    localparam logic [1:0] okay = `NEC_RESP_OKAY;
    localparam logic [1:0] slverr = `NEC_RESP_SLVERR;
    logic          clk = 1'b0, rst = 1'b1;
    logic [11:0]   awaddr = 12'h0, araddr = 12'h0;
    logic [31:0]   wdata = 32'h0;
    logic [3:0]    wstrb = 4'hF;
    logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire           awready, wready, bvalid, arready, rvalid, wstb, fvalid, done;
    wire  [1:0]    bresp, rresp;
    wire  [31:0]   rdata, wbuf, fword;
    wire  [2:0]    busy, mode;
    wire  [4:0]    rsts;
    wire  [12:0]   res;
    wire  [103:0]  pos;
    logic [103:0]  pv;
    int            failures = 0, checks_done = 0, cycles = 0;

    always #10 clk = ~clk;

    nec_regs uut (
        .REF_CLK(clk), .RESET(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CHIEN_SEARCH_BUSY(busy[2]), .LOCATOR_CALC_BUSY(busy[1]), .SYNDROME_BUSY(busy[0]),
        .FIXED_WORD_VALID(fvalid), .FIXED_WORD(fword), .SECTOR_DONE(done),
        .SECTOR_INDEX(res[12:10]), .DONE_OUTCOME(res[9:8]), .DONE_COUNT(res[3:0]),
        .DONE_POST_FIX_CRC(res[7]), .DONE_SEARCH_UNCORR(res[6]), .DONE_LOCATOR_UNCORR(res[5]),
        .DONE_ZERO_SYN_CRC(res[4]), .DONE_POSITIONS(pos),
        .ECC_WORD_BUFFER(wbuf), .ECC_WORD_STROBE(wstb), .CODE_STRENGTH_SELECT(mode[0]),
        .AUTO_FIX_SELECT(mode[1]), .DIRECTION_SELECT(mode[2]),
        .FLASH_CTRL_RESET(rsts[4]), .UNIT_RESET(rsts[3:0])
    );

    nec_engine_model eng (
        .ref_clk(clk), .ecc_word_buffer(wbuf), .ecc_word_strobe(wstb), .stage_busy(busy),
        .fixed_word_valid(fvalid), .fixed_word(fword), .sector_done(done), .result(res),
        .positions(pos)
    );

    // ----------------
    // Checking and bus tasks
    // ----------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Every bus task starts one edge on, so no signal is assigned twice in a step
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("write response", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk($sformatf("read %h", a), rdata, exp);
        chk("read response", {30'h0, rresp}, {30'h0, er});
    endtask

    task automatic sector(input logic [12:0] r, input logic [103:0] p, input logic [31:0] exp);
        eng.report(r, p);
        rd(`NEC_OFS_OUTCOME + 12'(r[12:10]) * 12'h4, exp, okay);
    endtask

    task automatic pos_chk(input logic [2:0] s, input int valid_pairs);
        for (int j = 0; j < 4; j++) begin
            rd(`NEC_OFS_POS + 12'(s) * 12'h10 + 12'(j) * 12'h4, j < valid_pairs ?
               {3'h0, pv[13*(2*j+1)+:13], 3'h0, pv[13*(2*j)+:13]} : 32'h0, okay);
        end
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        for (int k = 0; k < 8; k++) pv[13*k+:13] = 13'h1A00 + 13'(k);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a <= 24; a += 4) rd(12'(a), 32'h0, okay);
        wr(`NEC_OFS_SWRST, 32'h1F, okay);
        rd(`NEC_OFS_SWRST, 32'h0, okay);
        wr(`NEC_OFS_UNLOCK, 32'h6A, okay);
        wr(`NEC_OFS_SWRST, 32'h1F, okay);
        chk("resets while locked", {27'h0, rsts}, 32'h0);
        wr(`NEC_OFS_UNLOCK, 32'hFFFF_FF6B, okay);
        rd(`NEC_OFS_UNLOCK, 32'h6B, okay);
        for (int i = 0; i < 5; i++) begin
            wr(`NEC_OFS_SWRST, 32'hFFFF_FFE0 | (32'h1 << i), okay);
            chk("reset lines", {27'h0, rsts}, 32'h1 << i);
            rd(`NEC_OFS_SWRST, 32'h1 << i, okay);
        end
        wr(`NEC_OFS_UNLOCK, 32'h0, okay);
        wr(`NEC_OFS_SWRST, 32'h0, okay);
        chk("reset lines relocked", {27'h0, rsts}, 32'h10);
        // Mid-run reset with the key open must lock it again
        wr(`NEC_OFS_UNLOCK, 32'h6B, okay);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`NEC_OFS_UNLOCK, 32'h0, okay);
        chk("reset lines after reset", {27'h0, rsts}, 32'h0);
        wr(`NEC_OFS_SWRST, 32'h1F, okay);
        chk("reset lines locked after reset", {27'h0, rsts}, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wr(`NEC_OFS_MODE, 32'hFFFF_FFF8 | 32'(m), okay);
            chk("mode lines", {29'h0, mode}, 32'(m));
        end
        wr(`NEC_OFS_DATA_WIN, 32'h5A3C_96E1, okay);
        chk("engine word", wbuf, 32'h5A3C_96E1);
        rd(`NEC_OFS_DATA_WIN, 32'h5A3C_96E1, okay);
        rd(`NEC_OFS_FIX_WIN, 32'h5A3C_97E1, okay);
        wr(`NEC_OFS_FIX_WIN, 32'hFFFF_FFFF, okay);
        rd(`NEC_OFS_FIX_WIN, 32'h5A3C_97E1, okay);
        // Byte strobes: only the low byte of the window may change
        wstrb <= 4'h1;
        wr(`NEC_OFS_DATA_WIN, 32'hFFFF_FF22, okay);
        rd(`NEC_OFS_DATA_WIN, 32'h5A3C_9622, okay);
        rd(`NEC_OFS_FIX_WIN, 32'h5A3C_9722, okay);
        wstrb <= 4'hF;
        for (int i = 0; i < 4; i++) begin
            eng.set_stages(3'h1 << i);
            repeat (4) @(posedge clk);
            rd(`NEC_OFS_BUSY, (32'h1 << i) & 32'h7, okay);
        end
        wr(`NEC_OFS_BUSY, 32'hFFFF_FFFF, okay);
        rd(`NEC_OFS_BUSY, 32'h0, okay);
        wr(`NEC_OFS_MODE, 32'h7, okay);
        sector({3'd2, 2'b01, 4'b1000, 4'h8}, pv, 32'h108);
        pos_chk(3'd2, 4);
        rd(`NEC_OFS_SUMMARY, 32'h0, okay);
        sector({3'd2, 2'b00, 4'b0000, 4'h0}, ~pv, 32'h108);
        pos_chk(3'd2, 4);
        rd(`NEC_OFS_SUMMARY, 32'h4, okay);
        sector({3'd7, 2'b10, 4'b0111, 4'hF}, pv, 32'h27F);
        pos_chk(3'd7, 0);
        wr(`NEC_OFS_OUTCOME + 12'h1C, 32'h0, okay);
        rd(`NEC_OFS_OUTCOME + 12'h1C, 32'h27F, okay);
        wr(`NEC_OFS_MODE, 32'h6, okay);
        sector({3'd4, 2'b01, 4'b1001, 4'h4}, pv, 32'h194);
        pos_chk(3'd4, 2);
        wr(`NEC_OFS_MODE, 32'h4, okay);
        sector({3'd5, 2'b01, 4'b1000, 4'h1}, pv, 32'h101);
        sector({3'd5, 2'b00, 4'b0000, 4'h0}, pv, 32'h0);
        rd(`NEC_OFS_SUMMARY, 32'h24, okay);
        rd(12'h800, 32'h0, slverr);
        wr(12'h800, 32'h1, slverr);
        test_done();
    end
endmodule
`default_nettype wire
